// ### common/rtccal_pkg.sv
package rtccal_pkg;

  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned TRIM_WIDTH = 10;
  localparam int unsigned PRESCALE_WIDTH = 16;
  localparam int unsigned STALL_WIDTH = 12;

  // register word offsets; each register has clear, set and invert aliases at +4, +8, +C
  localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET = 12'h200;
  localparam logic [ADDR_WIDTH-1:0] TIME_OFFSET = 12'h220;

  localparam logic [DATA_WIDTH-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_WIDTH-1:0] CTRL_WRITABLE = 32'h03FF_A089;

  localparam int unsigned TRIM_LSB = 16;
  localparam int unsigned TRIM_MSB = 25;
  localparam int unsigned ENABLE_BIT = 15;
  localparam int unsigned IDLE_STOP_BIT = 13;
  localparam int unsigned SOURCE_SEL_BIT = 7;
  localparam int unsigned RUNNING_BIT = 6;
  localparam int unsigned UNLOCK_BIT = 3;
  localparam int unsigned RIPPLE_BIT = 2;
  localparam int unsigned HALF_BIT = 1;
  localparam int unsigned OE_BIT = 0;
  localparam int unsigned SECONDS_LANE = 1;

  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
  localparam logic [PRESCALE_WIDTH-1:0] RIPPLE_WINDOW = 16'h0020;

  localparam int unsigned CLOCK_PERIOD_NS = 40;
  localparam int unsigned CRYSTAL_PERIOD_NS = 30518;
  localparam int unsigned STALL_CYCLES = (2 * CRYSTAL_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [STALL_WIDTH-1:0] STALL_LIMIT = STALL_WIDTH'(STALL_CYCLES);

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLEAR = 2'h1,
    OP_SET   = 2'h2,
    OP_INV   = 2'h3
  } rtccal_op_type;

  typedef enum logic [2:0] {
    REGION_NONE = 3'h1,
    REGION_CTRL = 3'h2,
    REGION_TIME = 3'h4
  } rtccal_region_type;

endpackage : rtccal_pkg

// ### rtl/rtccal_sync.sv
`timescale 1ns/100ps
module rtccal_sync (
  input  logic clock,    // bus clock
  input  logic reset_n,  // power-on reset, active low
  input  logic async_in, // level from outside the clock domain
  output logic sync_out  // level after two flip-flops
);

  logic stage_reg;

  // the first stage feeds only the second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage_reg <= 1'b0;
      sync_out  <= 1'b0;
    end
    else
    begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end

endmodule : rtccal_sync

// ### rtl/rtccal_trim.sv
`timescale 1ns/100ps
module rtccal_trim (
  input  logic                                   clock,        // bus clock
  input  logic                                   reset_n,      // power-on reset, active low
  input  logic                                   restart,      // drops pending adjustment
  input  logic                                   crystal_tick, // one pulse per crystal cycle
  input  logic                                   minute_pulse, // one pulse per counted minute
  input  logic [rtccal_pkg::TRIM_WIDTH-1:0]      trim_value,   // signed drift trim
  output logic                                   count_tick,   // adjusted tick to the prescaler
  output logic [rtccal_pkg::TRIM_WIDTH-1:0]      pending       // adjustments still owed this minute
);

  logic                                 negative_reg;
  logic [rtccal_pkg::TRIM_WIDTH-1:0]    magnitude;
  logic                                 consume;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // the most negative code maps to 512, which still fits unsigned in ten bits
  assign magnitude = trim_value[rtccal_pkg::TRIM_WIDTH-1] ? (~trim_value + 10'h001) : trim_value;
  // removals eat real crystal ticks; insertions use idle bus cycles between them
  assign consume = (pending != 10'h000) && (negative_reg ? crystal_tick : !crystal_tick);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pending      <= 10'h000;
      negative_reg <= 1'b0;
    end
    else if (restart)
    begin
      pending      <= 10'h000;
      negative_reg <= 1'b0;
    end
    else if (minute_pulse)
    begin
      pending      <= magnitude;
      negative_reg <= trim_value[rtccal_pkg::TRIM_WIDTH-1];
    end
    else if (consume)
    begin
      pending <= pending - 10'h001;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_tick <= 1'b0;
    end
    else if (restart)
    begin
      count_tick <= 1'b0;
    end
    else if (negative_reg)
    begin
      count_tick <= crystal_tick && (pending == 10'h000);
    end
    else
    begin
      count_tick <= crystal_tick || (pending != 10'h000);
    end
  end

  a_neg_trim_swallow: assert property (negative_reg && pending != 10'h000 && crystal_tick && !restart
    && !minute_pulse |=> !count_tick && pending == $past(pending) - 10'h001)
    else $error("negative trim let a crystal tick through");

  a_pos_trim_insert: assert property (!negative_reg && pending != 10'h000 && !crystal_tick && !restart
    && !minute_pulse |=> count_tick)
    else $error("positive trim did not insert a tick");

  a_zero_trim_pass: assert property (minute_pulse && trim_value == 10'h000 && !restart
    |=> pending == 10'h000 ##1 count_tick == $past(crystal_tick))
    else $error("zero trim altered the tick stream");

endmodule : rtccal_trim

// ### rtl/rtccal_control.sv
`timescale 1ns/100ps
// Contract
// - drift trim is ten bits at 25..16, read as a signed integer
// - negative trim removes that many crystal pulses each minute, up to 512
// - positive trim inserts that many extra pulses each minute, up to 511
// - zero trim leaves counting alone; one adds exactly one pulse per minute
// - bit 15 enables the clock-calendar module
// - bit 13 stops the bus clock to the module while the processor idles
// - bit 7 picks seconds clock when set, alarm pulse when clear, for the pin
// - read-only bit 6 shows whether the crystal clock is running; here it reads zero while bit 15 is clear, except in a read set up right after the clear
// - enable bit writes are ignored unless the write unlock bit is one
// - the pin carries the selected source only while output enable is one
// - write unlock bit may be set only while the system unlock sequence is open
// - half-second flag is read-only and cleared by a write to seconds 14..8
// - control register is reset only by power-on reset
// - unimplemented bits 31..26, 14, 12..8, 5..4 read as zero
// - bit 3 unlocks software writes to time and date registers
// - bit 1 reads one in the second half of each second
// - bit 0 enables the clock output onto the pin
// - bit 2 reads one while a rollover ripple may spoil value reads
module rtccal_control #(
  parameter int unsigned TICKS_PER_SECOND = 32768  // crystal ticks per second
) (
  input  logic                                   clock,              // 25 MHz bus clock
  input  logic                                   reset_n,            // power-on reset, active low
  input  logic [rtccal_pkg::ADDR_WIDTH-1:0]      paddr,              // apb address
  input  logic                                   psel,               // apb select
  input  logic                                   penable,            // apb enable
  input  logic                                   pwrite,             // apb direction
  input  logic [rtccal_pkg::DATA_WIDTH-1:0]      pwdata,             // apb write data
  input  logic [3:0]                             pstrb,              // apb byte strobes
  output logic [rtccal_pkg::DATA_WIDTH-1:0]      prdata,             // apb read data
  output logic                                   pready,             // apb ready
  output logic                                   pslverr,            // apb error
  input  logic                                   crystal_in,         // 32.768 kHz crystal level
  input  logic                                   warm_reset,         // any non power-on reset
  input  logic                                   unlock_open,        // system unlock sequence done
  input  logic                                   cpu_idle,           // processor in idle
  input  logic                                   alarm_pulse,        // alarm pulse from alarm logic
  output logic                                   bus_clock_stop,     // request to gate bus clock
  output logic                                   pin_o,              // output pin level
  output logic                                   pin_oe,             // output pin drive enable
  output logic                                   value_write_strobe, // accepted time or date write
  output logic [5:0]                             seconds_count       // seconds within the minute
);

  localparam logic [rtccal_pkg::PRESCALE_WIDTH-1:0] LAST_TICK =
    rtccal_pkg::PRESCALE_WIDTH'(TICKS_PER_SECOND - 1);
  localparam logic [rtccal_pkg::PRESCALE_WIDTH-1:0] HALF_TICK =
    rtccal_pkg::PRESCALE_WIDTH'(TICKS_PER_SECOND / 2);

  logic [rtccal_pkg::DATA_WIDTH-1:0]       ctrl_reg;
  logic [rtccal_pkg::DATA_WIDTH-1:0]       ctrl_next;
  logic [rtccal_pkg::DATA_WIDTH-1:0]       read_next;
  logic [rtccal_pkg::PRESCALE_WIDTH-1:0]   prescale_reg;
  logic [rtccal_pkg::STALL_WIDTH-1:0]      stall_reg;
  rtccal_pkg::rtccal_region_type           setup_region;
  rtccal_pkg::rtccal_region_type           access_region;
  logic                                    access;
  logic                                    ctrl_write;
  logic                                    time_write;
  logic                                    seconds_write;
  logic                                    crystal_sync;
  logic                                    crystal_last_reg;
  logic                                    crystal_tick;
  logic                                    count_tick;
  logic                                    minute_pulse_reg;
  logic                                    running_reg;
  logic                                    enable;
  logic                                    unlock;
  logic                                    half_flag;
  logic                                    ripple_flag;
  logic                                    chain_restart;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  function automatic rtccal_pkg::rtccal_region_type decode_region(input logic [rtccal_pkg::ADDR_WIDTH-1:0] addr);
    if (addr[1:0] != 2'h0)
      return rtccal_pkg::REGION_NONE;
    else if (addr[11:4] == rtccal_pkg::CTRL_OFFSET[11:4])
      return rtccal_pkg::REGION_CTRL;
    else if (addr[11:4] == rtccal_pkg::TIME_OFFSET[11:4])
      return rtccal_pkg::REGION_TIME;
    else
      return rtccal_pkg::REGION_NONE;
  endfunction : decode_region

  function automatic logic [31:0] apply_op(input logic [31:0] old_value,
                                           input logic [31:0] data,
                                           input logic [1:0]  op_code);
    unique case (rtccal_pkg::rtccal_op_type'(op_code))
      rtccal_pkg::OP_WRITE: return data;
      rtccal_pkg::OP_CLEAR: return old_value & ~data;
      rtccal_pkg::OP_SET:   return old_value | data;
      rtccal_pkg::OP_INV:   return old_value ^ data;
    endcase
  endfunction : apply_op

  function automatic logic [31:0] lane_mask(input logic [3:0] strobes);
    return {{8{strobes[3]}}, {8{strobes[2]}}, {8{strobes[1]}}, {8{strobes[0]}}};
  endfunction : lane_mask

  assign enable = ctrl_reg[rtccal_pkg::ENABLE_BIT];
  assign unlock = ctrl_reg[rtccal_pkg::UNLOCK_BIT];

  // zero wait states, so the register bus never stalls; a read set up in the cycle
  // right after an enable clear still captures bit 6 as one here
  assign pready = 1'b1;
  assign access = psel && penable;
  assign setup_region = decode_region(paddr);
  assign access_region = decode_region(paddr);
  assign pslverr = access && (access_region == rtccal_pkg::REGION_NONE);
  assign ctrl_write = access && pwrite && (access_region == rtccal_pkg::REGION_CTRL);
  assign time_write = access && pwrite && (access_region == rtccal_pkg::REGION_TIME) && unlock;
  assign seconds_write = time_write && pstrb[rtccal_pkg::SECONDS_LANE];

  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    ctrl_next = ctrl_reg;
    if (ctrl_write)
    begin
      merged = (ctrl_reg & ~lane_mask(pstrb)) | (apply_op(ctrl_reg, pwdata, paddr[3:2]) & lane_mask(pstrb));
      ctrl_next = merged & rtccal_pkg::CTRL_WRITABLE;
      if (!unlock)
        ctrl_next[rtccal_pkg::ENABLE_BIT] = enable;
      if (!unlock && !unlock_open)
        ctrl_next[rtccal_pkg::UNLOCK_BIT] = 1'b0;
    end
  end

  // warm resets leave this register alone; only the power-on reset clears it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= rtccal_pkg::CTRL_RESET;
    else
      ctrl_reg <= ctrl_next;
  end

  always_comb
  begin
    read_next = 32'h0000_0000;
    unique case (setup_region)
      rtccal_pkg::REGION_CTRL:
      begin
        read_next = ctrl_reg & rtccal_pkg::CTRL_WRITABLE;
        read_next[rtccal_pkg::RUNNING_BIT] = running_reg;
        read_next[rtccal_pkg::RIPPLE_BIT] = ripple_flag;
        read_next[rtccal_pkg::HALF_BIT] = half_flag;
      end
      rtccal_pkg::REGION_TIME: read_next = 32'h0000_0000;
      rtccal_pkg::REGION_NONE: read_next = 32'h0000_0000;
      default: read_next = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup phase and stands through the access phase
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= read_next;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      value_write_strobe <= 1'b0;
    else
      value_write_strobe <= time_write;
  end

  rtccal_sync u_crystal_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (crystal_in),
    .sync_out (crystal_sync)
  );

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      crystal_last_reg <= 1'b0;
    else
      crystal_last_reg <= crystal_sync;
  end

  assign crystal_tick = crystal_sync && !crystal_last_reg;
  assign chain_restart = warm_reset || !enable;

  // a stopped crystal is seen as two crystal periods without an edge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      stall_reg <= rtccal_pkg::STALL_LIMIT;
    else if (crystal_tick)
      stall_reg <= 12'h000;
    else if (stall_reg != rtccal_pkg::STALL_LIMIT)
      stall_reg <= stall_reg + 12'h001;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      running_reg <= 1'b0;
    else
      running_reg <= enable && (stall_reg != rtccal_pkg::STALL_LIMIT);
  end

  rtccal_trim u_trim (
    .clock        (clock),
    .reset_n      (reset_n),
    .restart      (chain_restart),
    .crystal_tick (crystal_tick && enable),
    .minute_pulse (minute_pulse_reg),
    .trim_value   (ctrl_reg[rtccal_pkg::TRIM_MSB:rtccal_pkg::TRIM_LSB]),
    .count_tick   (count_tick),
    .pending      ()
  );

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prescale_reg <= 16'h0000;
    else if (chain_restart || seconds_write)
      prescale_reg <= 16'h0000;
    else if (count_tick)
      prescale_reg <= (prescale_reg == LAST_TICK) ? 16'h0000 : prescale_reg + 16'h0001;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seconds_count    <= 6'h00;
      minute_pulse_reg <= 1'b0;
    end
    else if (warm_reset)
    begin
      seconds_count    <= 6'h00;
      minute_pulse_reg <= 1'b0;
    end
    else
    begin
      minute_pulse_reg <= 1'b0;
      if (count_tick && enable && prescale_reg == LAST_TICK)
      begin
        if (seconds_count == rtccal_pkg::SECONDS_PER_MINUTE - 6'h01)
        begin
          seconds_count    <= 6'h00;
          minute_pulse_reg <= 1'b1;
        end
        else
        begin
          seconds_count <= seconds_count + 6'h01;
        end
      end
    end
  end

  assign half_flag = (prescale_reg >= HALF_TICK);
  // added, not subtracted: a second shorter than the window must not wrap below zero
  assign ripple_flag = enable && (prescale_reg + rtccal_pkg::RIPPLE_WINDOW >= LAST_TICK);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      bus_clock_stop <= 1'b0;
    else
      bus_clock_stop <= ctrl_reg[rtccal_pkg::IDLE_STOP_BIT] && cpu_idle;
  end

  // seconds clock is high in the first half of each second
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_o  <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      pin_oe <= ctrl_reg[rtccal_pkg::OE_BIT];
      if (!ctrl_reg[rtccal_pkg::OE_BIT])
        pin_o <= 1'b0;
      else if (ctrl_reg[rtccal_pkg::SOURCE_SEL_BIT])
        pin_o <= !half_flag;
      else
        pin_o <= alarm_pulse;
    end
  end

  a_trim_field_read: assert property (psel && !penable && !pwrite && paddr == rtccal_pkg::CTRL_OFFSET
    |=> prdata[25:16] == $past(ctrl_reg[25:16]))
    else $error("trim field read back wrong");

  a_disabled_hold: assert property (!enable && !seconds_write |=> prescale_reg == 16'h0000 ##1 !minute_pulse_reg)
    else $error("disabled module kept counting");

  a_idle_gate: assert property (ctrl_reg[13] && cpu_idle |=> bus_clock_stop)
    else $error("idle stop did not gate bus clock");

  a_pin_source: assert property (ctrl_reg[0] && ctrl_reg[7] |=> pin_oe && pin_o == !$past(half_flag))
    else $error("pin not carrying seconds clock");

  a_pin_gated: assert property (!ctrl_reg[0] |=> !pin_oe && !pin_o)
    else $error("pin active without output enable");

  a_running_flag: assert property (!enable |=> !running_reg)
    else $error("running flag set while disabled");

  a_enable_lock: assert property (ctrl_write && !unlock |=> enable == $past(enable))
    else $error("enable changed while locked");

  a_unlock_gate: assert property (!unlock && !unlock_open |=> !unlock)
    else $error("write unlock set without unlock sequence");

  a_half_clear: assert property (seconds_write |=> !half_flag && prescale_reg == 16'h0000)
    else $error("seconds write left half flag set");

  a_warm_keep: assert property (warm_reset && !ctrl_write |=> ctrl_reg == $past(ctrl_reg))
    else $error("warm reset disturbed control register");

  a_reserved_zero: assert property (psel && penable && !pwrite |-> (prdata & 32'hFC00_5F30) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");

  a_value_lock: assert property (access && pwrite && paddr[11:4] == 8'h22 && !unlock |=> !value_write_strobe)
    else $error("locked value register accepted a write");

endmodule : rtccal_control

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} rtccal_note_type;
  logic        clock = 0;
  logic        reset_n = 0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        crystal_in = 0;
  logic        crystal_on = 1;
  logic        warm_reset = 0;
  logic        unlock_open = 0;
  logic        cpu_idle = 0;
  logic        alarm_pulse = 0;
  logic        bus_clock_stop;
  logic        pin_o;
  logic        pin_oe;
  logic        value_write_strobe;
  logic [5:0]  seconds_count;
  int          err_total = 0;
  int          num_checks = 0;
  int          xcnt = 0;
  int          strobes = 0;
  int          seed = 87;
  int          cdiv = 0;
  int          trims [5] = '{0, 1, -1, 511, -512};
  rtccal_note_type notes [$];
  localparam logic [11:0] CTRL = rtccal_pkg::CTRL_OFFSET;

  // small second keeps a full minute at 960 crystal ticks
  rtccal_control #(.TICKS_PER_SECOND(16)) DUT (.clock(clock), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_in(crystal_in), .warm_reset(warm_reset), .unlock_open(unlock_open),
    .cpu_idle(cpu_idle), .alarm_pulse(alarm_pulse), .bus_clock_stop(bus_clock_stop), .pin_o(pin_o),
    .pin_oe(pin_oe), .value_write_strobe(value_write_strobe), .seconds_count(seconds_count));

  always #20 clock = ~clock;
  // crystal sped up to six bus cycles a period; parked low while stopped
  always @(posedge clock)
  begin
    cdiv <= (cdiv == 2) ? 0 : cdiv + 1;
    if (cdiv == 2)
      crystal_in <= crystal_on ? ~crystal_in : 1'b0;
  end
  always @(posedge crystal_in) xcnt++;
  always @(posedge clock) if (value_write_strobe === 1'b1) strobes++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite && notes.size() > 0)
    begin
      check(prdata & notes[0].mask, notes[0].data & notes[0].mask);
      check({31'h0, pslverr}, {31'h0, notes[0].err});
      void'(notes.pop_front());
    end
  end

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
    int n;
    rtccal_note_type nt;
    // idle cycle ahead of every setup keeps the slot after an enable clear free
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    nt.data = d;
    nt.mask = m;
    nt.err = (a == 12'h300);
    if (!w) notes.push_back(nt);
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      err_total++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wait_wrap();
    int n;
    logic [5:0] prev;
    prev = seconds_count;
    for (n = 0; n < 20000; n++)
    begin
      @(posedge clock);
      if (seconds_count === 6'h00 && prev !== 6'h00) return;
      prev = seconds_count;
    end
    err_total++;
    close_out();
  endtask : wait_wrap

  initial
  begin
    int s;
    logic [31:0] d;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    xfer(CTRL, 0, 32'h0000_0000, 32'hFFFF_FFFF);
    xfer(CTRL, 1, 32'hFFFF_FFFF, 0);
    xfer(CTRL, 0, 32'h03FF_2081, 32'hFFFF_FFFF);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clock);
    check({31'h0, bus_clock_stop}, 32'h1);
    check({30'h0, pin_oe, pin_o}, 32'h3);
    cpu_idle <= 1'b0;
    xfer(CTRL, 1, 32'h0000_0001, 0);
    alarm_pulse <= 1'b1;
    repeat (3) @(posedge clock);
    check({30'h0, pin_oe, pin_o}, 32'h3);
    xfer(CTRL, 1, 32'h0000_0000, 0);
    repeat (3) @(posedge clock);
    check({30'h0, pin_oe, pin_o}, 32'h0);
    s = strobes;
    pstrb <= 4'h2;
    xfer(rtccal_pkg::TIME_OFFSET, 1, 32'h0000_1200, 0);
    repeat (3) @(posedge clock);
    check(strobes - s, 0);
    pstrb <= 4'hF;
    unlock_open <= 1'b1;
    xfer(CTRL + 12'h8, 1, 32'h0000_0008, 0);
    unlock_open <= 1'b0;
    xfer(CTRL + 12'h8, 1, 32'h0000_8000, 0);
    repeat (100) @(posedge clock);
    xfer(CTRL, 0, 32'h0000_804C, 32'hFFFF_FFFD);
    pstrb <= 4'h2;
    xfer(rtccal_pkg::TIME_OFFSET, 1, 32'h0000_1200, 0);
    pstrb <= 4'hF;
    xfer(CTRL, 0, 32'h0000_804C, 32'h0000_0002);
    // nine crystal ticks after the seconds write puts the prescaler in the second half
    repeat (50) @(posedge clock);
    xfer(CTRL, 0, 32'h0000_0002, 32'h0000_0002);
    check(strobes - s, 1);
    xfer(CTRL + 12'h4, 1, 32'h0000_0008, 0);
    xfer(CTRL + 12'h4, 1, 32'h0000_8000, 0);
    warm_reset <= 1'b1;
    @(posedge clock);
    warm_reset <= 1'b0;
    xfer(CTRL, 0, 32'h0000_8044, 32'hFFFF_FFFD);
    crystal_on <= 1'b0;
    repeat (1600) @(posedge clock);
    xfer(CTRL, 0, 32'h0000_8004, 32'hFFFF_FFFD);
    crystal_on <= 1'b1;
    unlock_open <= 1'b1;
    xfer(CTRL + 12'h8, 1, 32'h0000_0008, 0);
    foreach (trims[i])
    begin
      xfer(CTRL, 1, {6'h00, 10'(trims[i]), 16'h8008}, 0);
      xfer(CTRL, 0, {6'h00, 10'(trims[i]), 16'h8008}, 32'hFFFF_FFB9);
      wait_wrap();
      s = xcnt;
      wait_wrap();
      check(xcnt - s, 960 - trims[i]);
    end
    repeat (4)
    begin
      d = $random(seed) | 32'h0000_0008;
      xfer(CTRL, 1, d, 0);
      xfer(CTRL, 0, d & rtccal_pkg::CTRL_WRITABLE, 32'hFFFF_FFB9);
    end
    // unmapped place answers with an error and zero data
    xfer(12'h300, 0, 32'h0000_0000, 32'hFFFF_FFFF);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule : tb_top
